// ==== tws_pkg.sv ====
// constants and types for the two-wire serial shift unit
package tws_pkg;
    // byte addresses of the four registers
    localparam logic [3:0] OFF_DATA     = 4'h0;
    localparam logic [3:0] OFF_STAT     = 4'h4;
    localparam logic [3:0] OFF_CTRL     = 4'h8;
    localparam logic [3:0] OFF_PORT     = 4'hc;
    // serial_control_reg fields
    localparam int         CTRL_SIE     = 7;
    localparam int         CTRL_OIE     = 6;
    localparam int         CTRL_WM      = 4;
    localparam int         CTRL_CS      = 2;
    localparam int         CTRL_CLK     = 1;
    localparam int         CTRL_TC      = 0;
    // serial_status_counter fields
    localparam int         STAT_SIF     = 7;
    localparam int         STAT_OIF     = 6;
    localparam int         STAT_PF      = 5;
    localparam int         STAT_DC      = 4;
    // pin control register fields
    localparam int         PORT_SDA     = 0;
    localparam int         PORT_SCL     = 1;
    localparam int         PORT_SDA_DIR = 2;
    localparam int         PORT_SCL_DIR = 3;
    // reset values
    localparam logic [7:0] DATA_RST     = 8'h00;
    localparam logic [3:0] CNT_RST      = 4'h0;
    localparam logic [7:0] CTRL_RST     = 8'h00;
    localparam logic [3:0] PORT_RST     = 4'h3;
    localparam logic [3:0] CNT_MAX      = 4'hf;
    // sda delay ahead of the start detector
    localparam int         CLK_NS       = 20;
    localparam int         SDA_DLY_NS   = 50;
    localparam int         SDA_DLY_CYC  = (SDA_DLY_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0] {
        TWS_WM_OFF,
        TWS_WM_THREE,
        TWS_WM_TWO,
        TWS_WM_TWO_ALT
    } tws_wm_e;

    typedef enum logic [1:0] {
        TWS_CS_SW,
        TWS_CS_TIMER,
        TWS_CS_EXT_POS,
        TWS_CS_EXT_NEG
    } tws_cs_e;

    typedef struct packed {
        logic    sie;
        logic    oie;
        tws_wm_e wm;
        tws_cs_e cs;
    } tws_ctrl_s;

    typedef struct packed {
        logic o;
        logic oe;
    } tws_pin_s;
endpackage

// ==== tws_serial_unit.sv ====
// two-wire serial shift unit with axi4-lite register slave
// How it works
// - two-wire start detector sets start flag
// - hold SCL low after start until flag cleared
// - slave shifts SDA in on SCL rise
// - overflow forces SCL low until flag cleared, two-wire only
// - start detector sees delayed SDA, two-wire only
// - start flag request drives WAKE_ANY, synchronous so the clock must run
// - external clock counts both edges
// - data writes win over a coincident shift
// - left shift clocked by selected source
// - shifting works even with outputs off
// - output latch follows bit 7 when open
// - non two-wire modes set start flag on count
// - start flag write-one-clear, gated interrupt request
// - overflow flag on 15 to 0 wrap
// - stop flag set on stop, no interrupt
// - collision when bit 7 differs from pin
// - counter readable, writable, counts selected clock
// - toggle strobe clocks when strobe mode set
// - counter wrap from F makes overflow interrupt
// - unaddressed slave released, waits for start
// - wire mode selects off, three-wire, two-wire
// - SDA pulled low when output bit zero
module tws_serial_unit (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] AWADDR,
    input  wire logic        WVALID,
    output logic             WREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    output logic             BVALID,
    input  wire logic        BREADY,
    output logic [1:0]       BRESP,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    input  wire logic [31:0] ARADDR,
    output logic             RVALID,
    input  wire logic        RREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE,
    input  wire logic        SCL_I,
    output logic             SCL_O,
    output logic             SCL_OE,
    output logic             DO_O,
    output logic             DO_OE,
    input  wire logic        TIMER_MATCH,
    input  wire logic        GLOBAL_IE,
    output logic             START_IRQ,
    output logic             OVF_IRQ,
    output logic             WAKE_ANY,
    output logic             WAKE_IDLE
);
    function automatic logic reg_hit(input logic [31:0] a, input logic [3:0] off);
        reg_hit = (a[31:4] == 28'h0) && (a[3:2] == off[3:2]);
    endfunction

    function automatic logic reg_known(input logic [31:0] a);
        reg_known = (a[31:4] == 28'h0);
    endfunction

    // ---------------- axi4-lite slave ----------------
    logic             aw_full;
    logic             w_full;
    logic [31:0]      wa;
    logic [31:0]      wd;
    logic [3:0]       ws;
    logic             wr_go;

    assign AWREADY = !aw_full;
    assign WREADY  = !w_full;
    // one write at a time: both halves held until the response leaves
    assign wr_go   = aw_full && w_full && !BVALID;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            aw_full <= 1'b0;
            wa      <= 32'h0;
        end else if (AWVALID && !aw_full) begin
            aw_full <= 1'b1;
            wa      <= AWADDR;
        end else if (BVALID && BREADY) begin
            aw_full <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            w_full <= 1'b0;
            wd     <= 32'h0;
            ws     <= 4'h0;
        end else if (WVALID && !w_full) begin
            w_full <= 1'b1;
            wd     <= WDATA;
            ws     <= WSTRB;
        end else if (BVALID && BREADY) begin
            w_full <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            BVALID <= 1'b0;
            BRESP  <= tws_pkg::RESP_OKAY;
        end else if (wr_go) begin
            BVALID <= 1'b1;
            BRESP  <= reg_known(wa) ? tws_pkg::RESP_OKAY : tws_pkg::RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // only byte lane 0 carries register bits
    logic             wr_data;
    logic             wr_stat;
    logic             wr_ctrl;
    logic             wr_port;
    logic [7:0]       wb;

    assign wb      = wd[7:0];
    assign wr_data = wr_go && ws[0] && reg_hit(wa, tws_pkg::OFF_DATA);
    assign wr_stat = wr_go && ws[0] && reg_hit(wa, tws_pkg::OFF_STAT);
    assign wr_ctrl = wr_go && ws[0] && reg_hit(wa, tws_pkg::OFF_CTRL);
    assign wr_port = wr_go && ws[0] && reg_hit(wa, tws_pkg::OFF_PORT);

    // ---------------- pin synchronisers ----------------
    logic [2:0]       sync [2];
    logic [1:0]       filt;
    logic [1:0]       filt_q;
    logic [1:0]       pin_in;

    assign pin_in = {SCL_I, SDA_I};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_sync
            // a change counts only once the last two stages agree
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    sync[i]   <= 3'h7;
                    filt[i]   <= 1'b1;
                    filt_q[i] <= 1'b1;
                end else begin
                    sync[i]   <= {sync[i][1:0], pin_in[i]};
                    filt[i]   <= (sync[i][1] == sync[i][2]) ? sync[i][2] : filt[i];
                    filt_q[i] <= filt[i];
                end
            end
        end
    endgenerate

    logic             sda_f;
    logic             scl_f;
    logic             scl_rise;
    logic             scl_fall;

    assign sda_f    = filt[0];
    assign scl_f    = filt[1];
    assign scl_rise = scl_f && !filt_q[1];
    assign scl_fall = !scl_f && filt_q[1];

    // ---------------- control and pin registers ----------------
    tws_pkg::tws_ctrl_s ctrl;
    logic             strobe_mode;
    logic [3:0]       port;
    logic             two_wire;
    logic             sw_clk;
    logic             tc_clk;

    assign two_wire = ctrl.wm[1];
    assign sw_clk   = wr_ctrl && wb[tws_pkg::CTRL_CLK];
    assign tc_clk   = wr_ctrl && wb[tws_pkg::CTRL_TC];

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ctrl        <= tws_pkg::tws_ctrl_s'(tws_pkg::CTRL_RST[7:2]);
            strobe_mode <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl        <= tws_pkg::tws_ctrl_s'(wb[7:2]);
            strobe_mode <= wb[tws_pkg::CTRL_CLK] && wb[tws_pkg::CTRL_CS + 1];
        end
    end

    // toggle strobe flips the scl port bit, as a master clocking by software
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            port <= tws_pkg::PORT_RST;
        end else if (wr_port) begin
            port <= wb[3:0];
        end else if (tc_clk) begin
            port[tws_pkg::PORT_SCL] <= !port[tws_pkg::PORT_SCL];
        end
    end

    // ---------------- clock selection ----------------
    logic             shift_tick;
    logic             count_tick;
    logic             tc_shift;

    // the strobe shifts only on the port edge matching the selected polarity
    assign tc_shift = tc_clk && (port[tws_pkg::PORT_SCL] == ctrl.cs[0]);

    always_comb begin
        shift_tick = 1'b0;
        count_tick = 1'b0;
        case (ctrl.cs)
            tws_pkg::TWS_CS_SW: begin
                shift_tick = sw_clk;
                count_tick = sw_clk;
            end
            tws_pkg::TWS_CS_TIMER: begin
                shift_tick = TIMER_MATCH;
                count_tick = TIMER_MATCH;
            end
            tws_pkg::TWS_CS_EXT_POS: begin
                shift_tick = strobe_mode ? tc_shift : scl_rise;
                count_tick = strobe_mode ? tc_clk : (scl_rise || scl_fall);
            end
            tws_pkg::TWS_CS_EXT_NEG: begin
                shift_tick = strobe_mode ? tc_shift : scl_fall;
                count_tick = strobe_mode ? tc_clk : (scl_rise || scl_fall);
            end
            default: begin
                shift_tick = 1'b0;
                count_tick = 1'b0;
            end
        endcase
    end

    // ---------------- shift register and counter ----------------
    logic [7:0]       data;
    logic [3:0]       cnt;
    logic             wrap;

    // shifting ignores wire mode, so it runs with outputs off too
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            data <= tws_pkg::DATA_RST;
        end else if (wr_data) begin
            data <= wb;
        end else if (shift_tick) begin
            data <= {data[6:0], sda_f};
        end
    end

    assign wrap = count_tick && (cnt == tws_pkg::CNT_MAX);

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            cnt <= tws_pkg::CNT_RST;
        end else if (wr_stat) begin
            cnt <= wb[3:0];
        end else if (count_tick) begin
            cnt <= cnt + 4'h1;
        end
    end

    // ---------------- output latch ----------------
    logic             latch_open;
    logic             latch_q;
    logic             out_bit;

    // opens on the half cycle opposite the sampling edge
    assign latch_open = !ctrl.cs[1] || (ctrl.cs[0] ? scl_f : !scl_f);
    assign out_bit    = latch_open ? data[7] : latch_q;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            latch_q <= 1'b0;
        end else if (latch_open) begin
            latch_q <= data[7];
        end
    end

    // ---------------- start and stop detection ----------------
    logic [tws_pkg::SDA_DLY_CYC:0] sda_dly;
    logic             start_det;
    logic             stop_det;

    // delayed sda keeps scl sampling valid around the sda edge
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            sda_dly <= '1;
        end else begin
            sda_dly <= {sda_dly[tws_pkg::SDA_DLY_CYC - 1:0], sda_f};
        end
    end

    assign start_det = two_wire && scl_f && sda_dly[tws_pkg::SDA_DLY_CYC]
                       && !sda_dly[tws_pkg::SDA_DLY_CYC - 1];
    assign stop_det  = two_wire && scl_f && !sda_dly[tws_pkg::SDA_DLY_CYC]
                       && sda_dly[tws_pkg::SDA_DLY_CYC - 1];

    // ---------------- status flags ----------------
    logic             sif;
    logic             oif;
    logic             pf;
    logic             hold_start;
    logic             hold_ovf;
    logic             sif_set;
    logic             clr_sif;
    logic             clr_oif;
    logic             clr_pf;

    assign clr_sif = wr_stat && wb[tws_pkg::STAT_SIF];
    assign clr_oif = wr_stat && wb[tws_pkg::STAT_OIF];
    assign clr_pf  = wr_stat && wb[tws_pkg::STAT_PF];
    assign sif_set = two_wire ? start_det : count_tick;

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            sif <= 1'b0;
        end else begin
            sif <= sif_set || (sif && !clr_sif);
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            oif <= 1'b0;
        end else begin
            oif <= wrap || (oif && !clr_oif);
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pf <= 1'b0;
        end else begin
            pf <= stop_det || (pf && !clr_pf);
        end
    end

    // hold starts at the first scl fall after the start, ends with the flag
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            hold_start <= 1'b0;
        end else begin
            hold_start <= two_wire && sif && (hold_start || scl_fall);
        end
    end

    // clearing the overflow flag releases scl, also for an unaddressed slave
    assign hold_ovf = two_wire && oif;

    // ---------------- pins ----------------
    tws_pkg::tws_pin_s sda_pin;
    tws_pkg::tws_pin_s scl_pin;
    tws_pkg::tws_pin_s do_pin;

    always_comb begin
        sda_pin = '0;
        scl_pin = '0;
        do_pin  = '0;
        case (ctrl.wm)
            tws_pkg::TWS_WM_THREE: begin
                do_pin.o  = out_bit;
                do_pin.oe = port[tws_pkg::PORT_SDA_DIR];
                scl_pin.o  = port[tws_pkg::PORT_SCL];
                scl_pin.oe = port[tws_pkg::PORT_SCL_DIR];
            end
            tws_pkg::TWS_WM_TWO, tws_pkg::TWS_WM_TWO_ALT: begin
                // open drain: only ever pulls low
                sda_pin.oe = port[tws_pkg::PORT_SDA_DIR]
                             && (!out_bit || !port[tws_pkg::PORT_SDA]);
                scl_pin.oe = port[tws_pkg::PORT_SCL_DIR]
                             && (!port[tws_pkg::PORT_SCL] || hold_start || hold_ovf);
            end
            default: begin
                sda_pin = '0;
                scl_pin = '0;
                do_pin  = '0;
            end
        endcase
    end

    assign SDA_O  = sda_pin.o;
    assign SDA_OE = sda_pin.oe;
    assign SCL_O  = scl_pin.o;
    assign SCL_OE = scl_pin.oe;
    assign DO_O   = do_pin.o;
    assign DO_OE  = do_pin.oe;

    // requests; wake follows the synchronised detector, so the clock must run
    assign START_IRQ = sif && ctrl.sie && GLOBAL_IE;
    assign OVF_IRQ   = oif && ctrl.oie && GLOBAL_IE;
    assign WAKE_ANY  = START_IRQ;
    assign WAKE_IDLE = OVF_IRQ;

    // ---------------- read side ----------------
    logic [7:0]       rd_val;
    logic             coll;

    assign coll = data[7] ^ sda_f;

    always_comb begin
        rd_val = 8'h00;
        case (ARADDR[3:2])
            tws_pkg::OFF_DATA[3:2]: rd_val = data;
            tws_pkg::OFF_STAT[3:2]: rd_val = {sif, oif, pf, coll, cnt};
            tws_pkg::OFF_CTRL[3:2]: rd_val = {ctrl, 2'h0};
            tws_pkg::OFF_PORT[3:2]: rd_val = {4'h0, port};
            default:                rd_val = 8'h00;
        endcase
    end

    assign ARREADY = !RVALID;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            RVALID <= 1'b0;
            RDATA  <= 32'h0;
            RRESP  <= tws_pkg::RESP_OKAY;
        end else if (ARVALID && !RVALID) begin
            RVALID <= 1'b1;
            RDATA  <= reg_known(ARADDR) ? {24'h0, rd_val} : 32'h0;
            RRESP  <= reg_known(ARADDR) ? tws_pkg::RESP_OKAY : tws_pkg::RESP_SLVERR;
        end else if (RREADY) begin
            RVALID <= 1'b0;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    a_write_beats_shift: assert property (wr_data && shift_tick |=> data == $past(wb))
        else $error("shift overrode a data write");
    a_count_step: assert property (count_tick && !wr_stat |=> cnt == $past(cnt) + 4'h1)
        else $error("counter did not step");
    a_wrap_sets_ovf: assert property (wrap |=> oif && cnt == 4'h0)
        else $error("wrap did not set overflow");
    a_ovf_holds_scl: assert property (two_wire && oif && port[tws_pkg::PORT_SCL_DIR] |-> SCL_OE)
        else $error("scl not held on overflow");
    a_start_sets_flag: assert property (start_det |=> sif)
        else $error("start not flagged");
    a_sif_sticky: assert property (sif && !clr_sif |=> sif)
        else $error("start flag lost");
    a_hold_release: assert property (hold_start && clr_sif && !sif_set |=> ##1 !hold_start)
        else $error("start hold not released");
    a_sda_pull: assert property (two_wire && port[tws_pkg::PORT_SDA_DIR] && !out_bit |-> SDA_OE)
        else $error("sda not pulled low");
    a_off_quiet: assert property (ctrl.wm == tws_pkg::TWS_WM_OFF |-> !SDA_OE && !SCL_OE && !DO_OE)
        else $error("outputs driven in off mode");
    a_stop_flag: assert property (stop_det |=> pf && !START_IRQ[*1])
        else $error("stop not flagged");
    a_both_edges: assert property (ctrl.cs[1] && !strobe_mode && (scl_rise || scl_fall) && !wr_stat
                                   |=> cnt != $past(cnt))
        else $error("external edge not counted");
    a_count_sets_sif: assert property (!two_wire && count_tick |=> sif)
        else $error("count did not set start flag");

    c_start_hold: cover property (start_det ##[1:200] hold_start);
    c_overflow: cover property (wrap && two_wire);
    c_stop: cover property (stop_det);
    c_write_read: cover property (BVALID ##[1:20] RVALID);
endmodule

// ==== tws_bus_master.sv ====
// two-wire bus master model driving scl and sda as open drain
module tws_bus_master (
    input  wire logic clk,
    input  wire logic scl_line,
    input  wire logic sda_line,
    output logic      scl_low,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // the slave may stretch, so wait for the line itself to go high
    task automatic rise_scl();
        int t;
        t = 0;
        scl_low <= 1'b0;
        do begin
            @(posedge clk);
            t++;
        end while (!scl_line && t < 400);
    endtask

    task automatic start_cond();
        @(posedge clk);
        sda_low <= 1'b1;
        repeat (8) @(posedge clk);
        scl_low <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    // data changes only mid low phase, away from scl edges
    task automatic send_bit(input logic b, output logic s);
        sda_low <= !b;
        repeat (4) @(posedge clk);
        rise_scl();
        repeat (4) @(posedge clk);
        s = sda_line;
        repeat (4) @(posedge clk);
        scl_low <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    task automatic stop_cond();
        sda_low <= 1'b1;
        repeat (4) @(posedge clk);
        rise_scl();
        repeat (8) @(posedge clk);
        sda_low <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
endmodule

// ==== tb_tws_serial_unit.sv ====
// self-checking bench for the two-wire serial shift unit
module tb_tws_serial_unit;
    timeunit 1ns;
    timeprecision 1ps;

    logic        CORE_CLK = 1'b0;
    logic        RST = 1'b1;
    logic        AWVALID = 1'b0;
    logic        WVALID = 1'b0;
    logic        BREADY = 1'b0;
    logic        ARVALID = 1'b0;
    logic        RREADY = 1'b0;
    logic        TIMER_MATCH = 1'b0;
    logic        GLOBAL_IE = 1'b1;
    logic [31:0] AWADDR = 32'h0;
    logic [31:0] WDATA = 32'h0;
    logic [31:0] ARADDR = 32'h0;
    logic [3:0]  WSTRB = 4'h0;
    logic [31:0] RDATA;
    logic [1:0]  BRESP, RRESP, rsp;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, SDA_I, SDA_O, SDA_OE, SCL_I, SCL_O, SCL_OE;
    logic        DO_O, DO_OE, START_IRQ, OVF_IRQ, WAKE_ANY, WAKE_IDLE, m_scl, m_sda, ack;
    logic [7:0]  rd;
    int          err_count = 0;
    int          n_tests = 0;

    // pull-ups on both lines, any party may pull low
    assign SCL_I = !((SCL_OE && !SCL_O) || m_scl);
    assign SDA_I = !((SDA_OE && !SDA_O) || m_sda);

    tws_serial_unit tws_serial_unit_i (.CORE_CLK, .RST, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA,
        .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY, .RDATA, .RRESP,
        .SDA_I, .SDA_O, .SDA_OE, .SCL_I, .SCL_O, .SCL_OE, .DO_O, .DO_OE, .TIMER_MATCH, .GLOBAL_IE,
        .START_IRQ, .OVF_IRQ, .WAKE_ANY, .WAKE_IDLE);
    tws_bus_master tws_bus_master_i (.clk(CORE_CLK), .scl_line(SCL_I), .sda_line(SDA_I), .scl_low(m_scl),
        .sda_low(m_sda));

    always #10 CORE_CLK = ~CORE_CLK;

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic do_reset();
        @(posedge CORE_CLK);
        RST <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        RST <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        AWVALID <= 1'b1;
        AWADDR <= a;
        WVALID <= 1'b1;
        WDATA <= {24'h0, d};
        WSTRB <= 4'h1;
        BREADY <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (!BVALID);
        BREADY <= 1'b0;
        rsp = BRESP;
    endtask

    task automatic rdr(input logic [31:0] a);
        @(posedge CORE_CLK);
        ARVALID <= 1'b1;
        ARADDR <= a;
        RREADY <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (ARREADY) ARVALID <= 1'b0;
        end while (!RVALID);
        RREADY <= 1'b0;
        rd = RDATA[7:0];
        rsp = RRESP;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [7:0] e);
        rdr(a);
        chk(rd, e);
    endtask

    task automatic t_reset();
        do_reset();
        rchk(tws_pkg::OFF_DATA, 8'h00);
        rchk(tws_pkg::OFF_STAT, 8'h10);
        rchk(tws_pkg::OFF_CTRL, 8'h00);
        rchk(tws_pkg::OFF_PORT, 8'h03);
        rdr(32'h10);
        chk(rsp, tws_pkg::RESP_SLVERR);
        wr(32'h10, 8'hff);
        chk(rsp, tws_pkg::RESP_SLVERR);
        rchk(tws_pkg::OFF_DATA, 8'h00);
    endtask

    task automatic t_count();
        do_reset();
        wr(tws_pkg::OFF_DATA, 8'h81);
        wr(tws_pkg::OFF_CTRL, 8'h02);
        rchk(tws_pkg::OFF_DATA, 8'h03);
        rchk(tws_pkg::OFF_STAT, 8'h91);
        wr(tws_pkg::OFF_STAT, 8'hcf);
        wr(tws_pkg::OFF_CTRL, 8'h44);
        @(posedge CORE_CLK);
        TIMER_MATCH <= 1'b1;
        @(posedge CORE_CLK);
        TIMER_MATCH <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        chk(OVF_IRQ, 1'b1);
        chk(WAKE_IDLE, 1'b1);
        chk(START_IRQ, 1'b0);
        rchk(tws_pkg::OFF_STAT, 8'hd0);
        GLOBAL_IE <= 1'b0;
        @(posedge CORE_CLK);
        @(posedge CORE_CLK);
        chk(OVF_IRQ, 1'b0);
        GLOBAL_IE <= 1'b1;
        wr(tws_pkg::OFF_STAT, 8'h40);
        chk(OVF_IRQ, 1'b0);
        rchk(tws_pkg::OFF_STAT, 8'h90);
        wr(tws_pkg::OFF_CTRL, 8'h84);
        chk(START_IRQ, 1'b1);
    endtask

    task automatic t_toggle();
        do_reset();
        wr(tws_pkg::OFF_CTRL, 8'h0a);
        wr(tws_pkg::OFF_STAT, 8'h80);
        // every strobe write repeats the clock strobe bit, or strobe mode drops
        wr(tws_pkg::OFF_CTRL, 8'h0b);
        wr(tws_pkg::OFF_CTRL, 8'h0b);
        rdr(tws_pkg::OFF_STAT);
        chk(rd & 8'h0f, 8'h02);
    endtask

    // outputs off: pins still clock and feed the shifter
    task automatic t_off();
        logic [3:0] bits;
        bits = 4'b1011;
        do_reset();
        // park scl low while the software source still ignores pin edges
        tws_bus_master_i.scl_low <= 1'b1;
        repeat (8) @(posedge CORE_CLK);
        wr(tws_pkg::OFF_CTRL, 8'h08);
        wr(tws_pkg::OFF_PORT, 8'h0f);
        for (int i = 3; i >= 0; i--) tws_bus_master_i.send_bit(bits[i], ack);
        rchk(tws_pkg::OFF_DATA, 8'h0b);
        rdr(tws_pkg::OFF_STAT);
        chk(rd & 8'h0f, 8'h08);
        chk(SCL_OE, 1'b0);
        // leave the bus idle for the start condition that follows
        tws_bus_master_i.rise_scl();
        repeat (8) @(posedge CORE_CLK);
    endtask

    task automatic t_i2c();
        logic [7:0] addr;
        addr = 8'ha5;
        do_reset();
        wr(tws_pkg::OFF_DATA, 8'hff);
        wr(tws_pkg::OFF_PORT, 8'h0f);
        wr(tws_pkg::OFF_CTRL, 8'he8);
        tws_bus_master_i.start_cond();
        repeat (4) @(posedge CORE_CLK);
        chk(SCL_OE, 1'b1);
        chk(START_IRQ, 1'b1);
        chk(WAKE_ANY, 1'b1);
        rdr(tws_pkg::OFF_STAT);
        chk(rd[7], 1'b1);
        wr(tws_pkg::OFF_STAT, 8'h80);
        repeat (3) @(posedge CORE_CLK);
        chk(SCL_OE, 1'b0);
        for (int i = 7; i >= 0; i--) tws_bus_master_i.send_bit(addr[i], ack);
        repeat (4) @(posedge CORE_CLK);
        chk(SCL_OE, 1'b1);
        chk(OVF_IRQ, 1'b1);
        rchk(tws_pkg::OFF_DATA, 8'ha5);
        rchk(tws_pkg::OFF_STAT, 8'h40);
        wr(tws_pkg::OFF_DATA, 8'h00);
        chk(SDA_OE, 1'b1);
        wr(tws_pkg::OFF_STAT, 8'h4e);
        tws_bus_master_i.send_bit(1'b1, ack);
        chk(ack, 1'b0);
        repeat (4) @(posedge CORE_CLK);
        chk(SCL_OE, 1'b1);
        wr(tws_pkg::OFF_DATA, 8'hff);
        wr(tws_pkg::OFF_STAT, 8'h40);
        tws_bus_master_i.stop_cond();
        rdr(tws_pkg::OFF_STAT);
        chk(rd[5], 1'b1);
        chk(START_IRQ, 1'b0);
    endtask

    initial begin
        repeat (3) @(posedge CORE_CLK);
        RST <= 1'b0;
        t_reset();
        t_count();
        t_toggle();
        t_off();
        t_i2c();
        final_report();
    end

    // whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        err_count++;
        final_report();
    end
endmodule
